// ===== verilog/ljs_regs.svh
// Register offsets, field positions, reset values and fixed codes of the serializer.
// Assumes it is included by bare name into the files that decode or build the frame.
`ifndef LJS_REGS_SVH
`define LJS_REGS_SVH

// ----------------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------------
`define LJS_ADDR_CTRL          8'h00
`define LJS_ADDR_FIRST_DELAY   8'h04
`define LJS_ADDR_SECOND_DELAY  8'h08
`define LJS_ADDR_STATUS        8'h0C
`define LJS_ADDR_WIDTH         8

// ----------------------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------------------
`define LJS_CTRL_ENABLE        0
`define LJS_CTRL_TIMESLOT      1
`define LJS_CTRL_SWAP          2
`define LJS_CTRL_INVERT        3
`define LJS_CTRL_WLEN_LO       4
`define LJS_CTRL_WLEN_HI       5
`define LJS_CTRL_FRAME_LO      6
`define LJS_CTRL_FRAME_HI      7
`define LJS_CTRL_RESET         8'h00
`define LJS_DELAY_RESET        8'h00

// ----------------------------------------------------------------------------
// Status fields
// ----------------------------------------------------------------------------
`define LJS_STAT_UNDERRUN      0
`define LJS_STAT_FRAME_ERR     1
`define LJS_STAT_FIFO_EMPTY    2
`define LJS_STAT_TS_ACTIVE     3
`define LJS_STAT_FBITS_LO      16
`define LJS_STAT_FBITS_HI      25

// ----------------------------------------------------------------------------
// Word lengths and bus answers
// ----------------------------------------------------------------------------
`define LJS_WLEN_16            10'h010
`define LJS_WLEN_20            10'h014
`define LJS_WLEN_24            10'h018
`define LJS_WLEN_32            10'h020
`define LJS_RESP_OKAY          2'h0
`define LJS_RESP_SLVERR        2'h2

`endif

// ===== verilog/ljs_pkg.sv
// Types shared by the audio serializer files.
// Assumes nothing beyond a SystemVerilog compiler.
package ljs_pkg;

  // Framing selection; only left-justified framing drives the data line.
  typedef enum logic [1:0] {
    LJS_FRM_LEFT,
    LJS_FRM_RIGHT,
    LJS_FRM_I2S,
    LJS_FRM_DSP
  } ljs_frame_e;

  // Word length selection codes.
  typedef enum logic [1:0] {
    LJS_WL_16,
    LJS_WL_20,
    LJS_WL_24,
    LJS_WL_32
  } ljs_wlen_e;

endpackage

// ===== verilog/ljs_fifo.sv
// Sample FIFO with registered read data and valid/ready on both sides.
// Assumes a single clock domain shared by writer and reader.
`timescale 1ns/1ns
module ljs_fifo #(
  parameter int WIDTH = 64,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             ce,
  // Fill side
  input  wire logic             wr_valid,
  output logic                  wr_ready,
  input  wire logic [WIDTH-1:0] wr_data,
  // Drain side
  output logic                  rd_valid,
  input  wire logic             rd_ready,
  output logic [WIDTH-1:0]      rd_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wptr_reg;
  logic [AW-1:0]    rptr_reg;
  logic [AW:0]      count_reg;
  logic             out_valid_reg;
  logic [WIDTH-1:0] out_data_reg;
  wire              push;
  wire              pop_mem;
  wire              out_free;

  // ----------------------------------------------------------------------------
  // Handshakes
  // ----------------------------------------------------------------------------
  assign wr_ready = (count_reg != (AW+1)'(DEPTH));
  assign push     = wr_valid && wr_ready;
  assign out_free = !out_valid_reg || rd_ready;
  assign pop_mem  = out_free && (count_reg != '0);
  assign rd_valid = out_valid_reg;
  assign rd_data  = out_data_reg;

  // ----------------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (ce && push) begin
      mem_reg[wptr_reg] <= wr_data;
    end
  end

  // The output register lets the consumer see data without a read delay.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wptr_reg      <= '0;
      rptr_reg      <= '0;
      count_reg     <= '0;
      out_valid_reg <= 1'b0;
      out_data_reg  <= '0;
    end else if (ce) begin
      if (push) begin
        wptr_reg <= (wptr_reg == AW'(DEPTH-1)) ? '0 : wptr_reg + 1'b1;
      end
      if (pop_mem) begin
        rptr_reg     <= (rptr_reg == AW'(DEPTH-1)) ? '0 : rptr_reg + 1'b1;
        out_data_reg <= mem_reg[rptr_reg];
      end
      if (out_free) begin
        out_valid_reg <= pop_mem;
      end
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop_mem);
    end
  end

endmodule

// ===== verilog/ljs_serializer.sv
// Left-justified stereo audio serializer with an AXI4-Lite register slave.
// Assumes bit clock and word clock arrive from outside and are slow against aclk.
//
// Summary of operation
// - Time-slot placement is never active while right-justified framing is chosen.
// - Standard framing: one MSB after word clock falls, the other after it rises.
// - Bit clocks per frame must exceed twice the word length; violations flagged.
// - First delay plus word length must not exceed bit clocks per frame; flagged.
// - Without time slots both channels use the first delay, each word-clock edge starts one.
// - Data bits are valid on bit-clock rising edges unless polarity is inverted.
// - With time slots the first channel starts after its own delay from word-clock rise.
// - With time slots the second channel starts second delay after first channel LSB.
// - With time slots the falling word-clock edge is ignored.
// - No swap, no slots: left MSB at edge delay+1 after rise, right after fall.
// - Swap, no slots: right MSB at edge delay+1 after rise, left after fall.
// - Slots, no swap: left first, right MSB second delay+1 edges after left LSB.
// - Slots and swap: right first, left MSB second delay+1 edges after right LSB.
// - The second-channel delay has its own register, separate from the first.
// - A control bit exchanges the order of the two channels.
// - A control bit inverts the bit-clock polarity in left-justified framing, the only one driven.
// - Words go MSB first with a width of 16, 20, 24 or 32 bits.
`timescale 1ns/1ns
`include "ljs_regs.svh"
module ljs_serializer #(
  parameter int SAMPLE_W   = 32,
  parameter int FIFO_DEPTH = 8,
  parameter int CNT_W      = 10
) (
  // Clock, reset and freeze
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic                ce,
  // AXI4-Lite write address
  input  wire logic [7:0]          s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [7:0]          s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  // Stereo sample stream
  input  wire logic [SAMPLE_W-1:0] smp_left,
  input  wire logic [SAMPLE_W-1:0] smp_right,
  input  wire logic                smp_valid,
  output logic                     smp_ready,
  // Audio serial pins
  input  wire logic                bclk,
  input  wire logic                wclk,
  output logic                     dout
);

  // ----------------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------------
  logic [7:0]          ctrl_reg;
  logic [7:0]          first_channel_delay_reg;
  logic [7:0]          second_channel_delay_reg;
  logic                underrun_reg;
  logic                frame_err_reg;
  logic [CNT_W-1:0]    frame_bits_reg;
  logic                have_frame_reg;

  logic                bclk_s1_reg;
  logic                bclk_s2_reg;
  logic                bclk_s3_reg;
  logic                wclk_s1_reg;
  logic                wclk_s2_reg;
  logic                wclk_last_reg;

  logic [CNT_W-1:0]    cnt_reg;
  logic [CNT_W-1:0]    fcnt_reg;
  logic                seg_reg;
  logic [SAMPLE_W-1:0] left_reg;
  logic [SAMPLE_W-1:0] right_reg;
  logic                dout_reg;

  logic                aw_held_reg;
  logic [7:0]          aw_addr_reg;
  logic                w_held_reg;
  logic [31:0]         w_data_reg;
  logic [3:0]          w_strb_reg;
  logic                bvalid_reg;
  logic [1:0]          bresp_reg;
  logic                rvalid_reg;
  logic [1:0]          rresp_reg;
  logic [31:0]         rdata_reg;

  logic                fifo_valid;
  logic [2*SAMPLE_W-1:0] fifo_data;

  // ----------------------------------------------------------------------------
  // Control decode
  // ----------------------------------------------------------------------------
  wire                 enable    = ctrl_reg[`LJS_CTRL_ENABLE];
  wire                 swap      = ctrl_reg[`LJS_CTRL_SWAP];
  wire                 invert    = ctrl_reg[`LJS_CTRL_INVERT];
  wire ljs_pkg::ljs_frame_e framing =
    ljs_pkg::ljs_frame_e'(ctrl_reg[`LJS_CTRL_FRAME_HI:`LJS_CTRL_FRAME_LO]);
  wire ljs_pkg::ljs_wlen_e  wsel    =
    ljs_pkg::ljs_wlen_e'(ctrl_reg[`LJS_CTRL_WLEN_HI:`LJS_CTRL_WLEN_LO]);
  wire                 is_left   = (framing == ljs_pkg::LJS_FRM_LEFT);
  wire                 ts_on     = ctrl_reg[`LJS_CTRL_TIMESLOT]
                                   && (framing != ljs_pkg::LJS_FRM_RIGHT);
  wire                 running   = enable && is_left;

  logic [CNT_W-1:0]    wlen;
  always_comb begin
    unique case (wsel)
      ljs_pkg::LJS_WL_16: wlen = `LJS_WLEN_16;
      ljs_pkg::LJS_WL_20: wlen = `LJS_WLEN_20;
      ljs_pkg::LJS_WL_24: wlen = `LJS_WLEN_24;
      ljs_pkg::LJS_WL_32: wlen = `LJS_WLEN_32;
    endcase
  end

  // ----------------------------------------------------------------------------
  // Sample FIFO
  // ----------------------------------------------------------------------------
  // A word clock rise takes one stereo pair; the writer is stalled when full.
  wire                 pop;

  ljs_fifo #(
    .WIDTH (2*SAMPLE_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .ce       (ce),
    .wr_valid (smp_valid),
    .wr_ready (smp_ready),
    .wr_data  ({smp_left, smp_right}),
    .rd_valid (fifo_valid),
    .rd_ready (pop),
    .rd_data  (fifo_data)
  );

  // ----------------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bclk_s1_reg <= 1'b0;
      bclk_s2_reg <= 1'b0;
      bclk_s3_reg <= 1'b0;
      wclk_s1_reg <= 1'b0;
      wclk_s2_reg <= 1'b0;
    end else if (ce) begin
      bclk_s1_reg <= bclk;
      bclk_s2_reg <= bclk_s1_reg;
      bclk_s3_reg <= bclk_s2_reg;
      wclk_s1_reg <= wclk;
      wclk_s2_reg <= wclk_s1_reg;
    end
  end

  // ----------------------------------------------------------------------------
  // Bit-clock edges
  // ----------------------------------------------------------------------------
  // The receiver samples on the active edge, so the line changes on the other one.
  wire bclk_rise = bclk_s2_reg && !bclk_s3_reg;
  wire bclk_fall = !bclk_s2_reg && bclk_s3_reg;
  wire drv_edge  = invert ? bclk_rise : bclk_fall;
  wire wclk_rise = drv_edge && wclk_s2_reg && !wclk_last_reg;
  wire wclk_fall = drv_edge && !wclk_s2_reg && wclk_last_reg;
  wire fall_used = wclk_fall && !ts_on;

  assign pop = running && wclk_rise && fifo_valid;

  // ----------------------------------------------------------------------------
  // Frame position
  // ----------------------------------------------------------------------------
  // The count names the active edge that comes next, one for the first after a word-clock rise, or after a fall without time slots.
  wire [CNT_W-1:0] cnt_sat  = (cnt_reg == '1) ? cnt_reg : cnt_reg + 1'b1;
  wire [CNT_W-1:0] fcnt_sat = (fcnt_reg == '1) ? fcnt_reg : fcnt_reg + 1'b1;
  wire [CNT_W-1:0] cnt_next = (wclk_rise || fall_used) ? CNT_W'(1) : cnt_sat;
  wire             seg_next = wclk_rise ? 1'b0 : (fall_used ? 1'b1 : seg_reg);

  wire [SAMPLE_W-1:0] left_next  = !wclk_rise ? left_reg :
                                   (pop ? fifo_data[2*SAMPLE_W-1:SAMPLE_W] : '0);
  wire [SAMPLE_W-1:0] right_next = !wclk_rise ? right_reg :
                                   (pop ? fifo_data[SAMPLE_W-1:0] : '0);

  // ----------------------------------------------------------------------------
  // Channel windows
  // ----------------------------------------------------------------------------
  wire [CNT_W-1:0] start1 = CNT_W'(first_channel_delay_reg) + 1'b1;
  wire [CNT_W-1:0] end1   = start1 + wlen;
  wire [CNT_W-1:0] start2 = end1 + CNT_W'(second_channel_delay_reg);
  wire [CNT_W-1:0] end2   = start2 + wlen;

  wire in_first  = !seg_next && (cnt_next >= start1) && (cnt_next < end1);
  wire in_second = ts_on ? ((cnt_next >= start2) && (cnt_next < end2))
                         : (seg_next && (cnt_next >= start1) && (cnt_next < end1));

  wire [CNT_W-1:0] rel    = cnt_next - (in_second && ts_on ? start2 : start1);
  wire [CNT_W-1:0] bitpos = wlen - 1'b1 - rel;

  // Swap puts the right word in the first slot.
  wire [SAMPLE_W-1:0] first_word  = swap ? right_next : left_next;
  wire [SAMPLE_W-1:0] second_word = swap ? left_next : right_next;
  wire [SAMPLE_W-1:0] cur_word    = in_first ? first_word : second_word;
  wire                bit_out     = (in_first || in_second) && cur_word[bitpos[4:0]];

  // ----------------------------------------------------------------------------
  // Serial state
  // ----------------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wclk_last_reg <= 1'b0;
      cnt_reg       <= '0;
      seg_reg       <= 1'b0;
      left_reg      <= '0;
      right_reg     <= '0;
      dout_reg      <= 1'b0;
    end else if (ce) begin
      if (!running) begin
        dout_reg <= 1'b0;
      end
      if (drv_edge) begin
        wclk_last_reg <= wclk_s2_reg;
        cnt_reg       <= cnt_next;
        seg_reg       <= seg_next;
        left_reg      <= left_next;
        right_reg     <= right_next;
        dout_reg      <= running && bit_out;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Frame length check
  // ----------------------------------------------------------------------------
  // The frame length is only known at the next rise, so a bad setting shows one frame late.
  wire fbits_short  = (fcnt_reg <= (wlen << 1));
  wire offset_large = (CNT_W'(first_channel_delay_reg) + wlen > fcnt_reg);
  wire slots_large  = ts_on && (end2 - 1'b1 > fcnt_reg);
  wire frame_bad    = running && wclk_rise && have_frame_reg
                      && (fbits_short || offset_large || slots_large);
  wire underrun_set = running && wclk_rise && !fifo_valid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fcnt_reg       <= '0;
      frame_bits_reg <= '0;
      have_frame_reg <= 1'b0;
    end else if (ce) begin
      if (!running) begin
        have_frame_reg <= 1'b0;
      end else if (wclk_rise) begin
        frame_bits_reg <= fcnt_reg;
        fcnt_reg       <= CNT_W'(1);
        have_frame_reg <= 1'b1;
      end else if (drv_edge) begin
        fcnt_reg <= fcnt_sat;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------------------
  wire        wr_fire   = aw_held_reg && w_held_reg && !bvalid_reg;
  wire        rd_fire   = s_axi_arvalid && s_axi_arready;
  wire        wr_ctrl   = wr_fire && (aw_addr_reg == `LJS_ADDR_CTRL);
  wire        wr_d1     = wr_fire && (aw_addr_reg == `LJS_ADDR_FIRST_DELAY);
  wire        wr_d2     = wr_fire && (aw_addr_reg == `LJS_ADDR_SECOND_DELAY);
  wire        wr_stat   = wr_fire && (aw_addr_reg == `LJS_ADDR_STATUS);
  wire        wr_hit    = wr_ctrl || wr_d1 || wr_d2 || wr_stat;
  wire        clr_under = wr_stat && w_strb_reg[0] && w_data_reg[`LJS_STAT_UNDERRUN];
  wire        clr_ferr  = wr_stat && w_strb_reg[0] && w_data_reg[`LJS_STAT_FRAME_ERR];

  wire [31:0] status_word = {6'h00, frame_bits_reg, 12'h000, ts_on, !fifo_valid,
                             frame_err_reg, underrun_reg};
  wire        rd_hit  = (s_axi_araddr == `LJS_ADDR_CTRL) || (s_axi_araddr == `LJS_ADDR_FIRST_DELAY)
                     || (s_axi_araddr == `LJS_ADDR_SECOND_DELAY) || (s_axi_araddr == `LJS_ADDR_STATUS);
  wire [31:0] rd_mux  = (s_axi_araddr == `LJS_ADDR_CTRL)         ? {24'h000000, ctrl_reg} :
                        (s_axi_araddr == `LJS_ADDR_FIRST_DELAY)  ? {24'h000000, first_channel_delay_reg} :
                        (s_axi_araddr == `LJS_ADDR_SECOND_DELAY) ? {24'h000000, second_channel_delay_reg} :
                        (s_axi_araddr == `LJS_ADDR_STATUS)       ? status_word : 32'h00000000;

  assign s_axi_awready = !aw_held_reg;
  assign s_axi_wready  = !w_held_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rresp   = rresp_reg;
  assign s_axi_rdata   = rdata_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_held_reg  <= 1'b0;
      w_data_reg  <= '0;
      w_strb_reg  <= '0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `LJS_RESP_OKAY;
    end else if (ce) begin
      if (s_axi_awvalid && !aw_held_reg) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_held_reg) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held_reg <= 1'b0;
        w_held_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        bresp_reg   <= wr_hit ? `LJS_RESP_OKAY : `LJS_RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rresp_reg  <= `LJS_RESP_OKAY;
      rdata_reg  <= '0;
    end else if (ce) begin
      if (rd_fire) begin
        rvalid_reg <= 1'b1;
        rresp_reg  <= rd_hit ? `LJS_RESP_OKAY : `LJS_RESP_SLVERR;
        rdata_reg  <= rd_mux;
      end else if (s_axi_rready) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------------------
  // Only the low byte lane carries configuration, so only strobe 0 matters.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg                 <= `LJS_CTRL_RESET;
      first_channel_delay_reg  <= `LJS_DELAY_RESET;
      second_channel_delay_reg <= `LJS_DELAY_RESET;
    end else if (ce && w_strb_reg[0]) begin
      if (wr_ctrl) begin
        ctrl_reg <= w_data_reg[7:0];
      end
      if (wr_d1) begin
        first_channel_delay_reg <= w_data_reg[7:0];
      end
      if (wr_d2) begin
        second_channel_delay_reg <= w_data_reg[7:0];
      end
    end
  end

  // Sticky flags: a new event in the clearing cycle keeps the flag set.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      underrun_reg  <= 1'b0;
      frame_err_reg <= 1'b0;
    end else if (ce) begin
      underrun_reg  <= underrun_set || (underrun_reg && !clr_under);
      frame_err_reg <= frame_bad || (frame_err_reg && !clr_ferr);
    end
  end

  assign dout = dout_reg;

endmodule

// ===== verification/ljs_serializer_properties.sv
// Port-level checks for the serializer, bound onto its top module.
// Assumes one clock domain, aclk, with synchronous active-low reset.
`timescale 1ns/1ns
module ljs_serializer_properties (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // Register bus handshakes
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Stream and serial pins
  input wire logic smp_valid,
  input wire logic smp_ready,
  input wire logic bclk,
  input wire logic dout
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_rst; $rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid && smp_ready && !dout; endproperty
  a_rst: assert property (p_rst) else $error("outputs not idle after reset");
  property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
  a_bhold: assert property (p_bhold) else $error("write answer dropped early");
  property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid; endproperty
  a_rhold: assert property (p_rhold) else $error("read answer dropped early");
  property p_rd; s_axi_arvalid && s_axi_arready && ce |=> s_axi_rvalid; endproperty
  a_rd: assert property (p_rd) else $error("read answer late");
  property p_ar; s_axi_rvalid && s_axi_rready && ce |=> !s_axi_rvalid; endproperty
  a_ar: assert property (p_ar) else $error("read answer not released after it was taken");
  property p_smp; $fell(smp_ready) |-> $past(smp_valid); endproperty
  a_smp: assert property (p_smp) else $error("stream ready fell without a push");
  property p_dst; $rose(bclk) |-> $stable(dout); endproperty
  a_dst: assert property (p_dst) else $error("data moved at sampling edge");
  property p_ce; !ce |=> $stable(dout) && $stable(s_axi_bvalid); endproperty
  a_ce: assert property (p_ce) else $error("outputs moved while frozen");
  cover property (s_axi_bvalid && s_axi_bready);
  cover property (s_axi_rvalid && s_axi_rready);
  cover property (!smp_ready);
endmodule
bind ljs_serializer ljs_serializer_properties u_props (.*);

// ===== verification/ljs_host.sv
// Host end of the serial link: makes bit and word clocks, samples data.
// Assumes the bench calls frame() while the serializer is idle between frames.
`timescale 1ns/1ns
module ljs_host #(
  parameter int HALF = 33
) (
  // Serial pins
  output logic             bclk,
  output logic             wclk,
  input  wire logic        dout,
  // Last frame, first sampling edge in the top bit
  output logic [2*HALF-1:0] cap
);
  initial begin
    bclk = 1'h0;
    wclk = 1'h0;
    cap = '0;
  end
  // The word clock moves on the driving edge; data are taken on the other.
  // HALF bits per level keep the frame over two 32-bit words.
  task automatic frame(input logic inv);
    #3 bclk = !inv;
    #80;
    for (int i = 0; i < 2 * HALF; i++) begin
      bclk = inv;
      wclk = (i < HALF);
      #80 bclk = !inv;
      cap[2*HALF-1-i] = dout;
      #80;
    end
  endtask
endmodule

// ===== verification/ljs_serializer_tb.sv
// Self-checking bench: register bus, sample pushes and serial frames.
// Assumes the host model answers on the serial pins.
`timescale 1ns/1ns
`include "ljs_regs.svh"
module ljs_serializer_tb;
  localparam int H = 33;
  typedef struct {logic [7:0] c, d1, d2; logic [31:0] l, r;} ljs_row_s;
  logic        aclk = 0, aresetn = 0, ce = 1, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0, smp_valid = 0, s_axi_awready, s_axi_wready;
  logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, smp_ready, bclk, wclk, dout;
  logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, smp_left = 0, smp_right = 0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [65:0] cap;
  int          err_total = 0, compares = 0;
  ljs_row_s    rows [7] = '{'{8'h01, 0, 0, 32'hA5C3, 32'h3C5A}, '{8'h15, 1, 0, 32'hABCDE, 32'h12345},
    '{8'h23, 0, 1, 32'hC0FFEE, 32'h812345}, '{8'h37, 0, 1, 32'hDEADBEEF, 32'h8BADF00D},
    '{8'h29, 2, 0, 32'hF0F00F, 32'h123456}, '{8'h13, 3, 5, 32'hF1E2D, 32'hA5A5A}, '{8'h31, 1, 0, 1, 2}};
  always #5 aclk = ~aclk;
  ljs_serializer dut (.*);
  ljs_host #(.HALF(H)) host (.*);
  task automatic chk(input string n, input logic [65:0] e, g);
    compares++;
    if (g !== e) begin err_total++; $display("mismatch %s expected %h seen %h", n, e, g); end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    bit pa = 1, pw = 1;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    while (pa || pw) begin
      @(posedge aclk);
      if (pa && s_axi_awready) begin s_axi_awvalid <= 1'h0; pa = 0; end
      if (pw && s_axi_wready) begin s_axi_wvalid <= 1'h0; pw = 0; end
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'h0;
    chk("bresp", r, s_axi_bresp);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'h0;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'h0;
    chk("rdata", e, s_axi_rdata);
    chk("rresp", r, s_axi_rresp);
  endtask
  task automatic push(input logic [31:0] l, r);
    @(posedge aclk);
    {smp_left, smp_right, smp_valid} <= {l, r, 1'h1};
    do @(posedge aclk); while (!smp_ready);
    smp_valid <= 1'h0;
  endtask
  // Sample bits sit at the low end; the first word follows d1 sampling edges.
  function automatic logic [65:0] fexp(input ljs_row_s x);
    int w = (x.c[5:4] == 2'h3) ? 32 : 16 + 4 * x.c[5:4];
    int s = x.c[1] ? x.d1 + w + x.d2 : H + x.d1;
    logic [31:0] a = x.c[2] ? x.r : x.l;
    logic [31:0] b = x.c[2] ? x.l : x.r;
    fexp = '0;
    for (int k = 0; k < w && x.c[7:6] == 2'h0; k++) {fexp[65-x.d1-k], fexp[65-s-k]} = {a[w-1-k], b[w-1-k]};
  endfunction
  task automatic run(input ljs_row_s x);
    wr(`LJS_ADDR_FIRST_DELAY, x.d1, 2'h0);
    wr(`LJS_ADDR_SECOND_DELAY, x.d2, 2'h0);
    wr(`LJS_ADDR_CTRL, x.c, 2'h0);
    if (x.c[7:6] == 2'h0) push(x.l, x.r);
    host.frame(x.c[3]);
    chk("frame", fexp(x), cap);
  endtask
  task automatic complete_run();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #400000 err_total++;
    complete_run();
  end
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'h1;
    rd(`LJS_ADDR_CTRL, 0, `LJS_RESP_OKAY);
    rd(8'h10, 0, `LJS_RESP_SLVERR);
    wr(8'h10, 1, `LJS_RESP_SLVERR);
    $display("test registers done");
    foreach (rows[i]) begin
      run(rows[i]);
      $display("test row %0d done", i);
    end
    run('{8'h43, 0, 1, 1, 2});
    rd(`LJS_ADDR_STATUS, 32'h00420004, 2'h0);
    for (int k = 0; k < 9; k++) push(32'h1111 * (k + 1), 32'h2222 * (k + 1));
    @(posedge aclk);
    chk("ready", 0, smp_ready);
    wr(`LJS_ADDR_CTRL, 8'h01, 2'h0);
    for (int k = 0; k < 9; k++) begin
      host.frame(1'h0);
      chk("drain", fexp('{8'h01, 0, 0, 32'h1111 * (k + 1), 32'h2222 * (k + 1)}), cap);
    end
    host.frame(1'h0);
    rd(`LJS_ADDR_STATUS, 32'h00420005, 2'h0);
    wr(`LJS_ADDR_STATUS, 1, 2'h0);
    rd(`LJS_ADDR_STATUS, 32'h00420004, 2'h0);
    $display("test buffer done");
    ce <= 1'h0;
    @(posedge aclk) ce <= 1'h1;
    @(posedge aclk) aresetn <= 1'h0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'h1;
    rd(`LJS_ADDR_CTRL, 0, `LJS_RESP_OKAY);
    $display("test second reset done");
    complete_run();
  end
endmodule
